// ===== rtl/bwd_defs.svh
// Purpose: Register map, fields, resets and timing for the byte-wide DIO port
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Values here are shared by the millisecond divider, the port and the bench
//
// Behaviour
// - A port write applies an 8-bit value to the selected port's outputs.
// - A port read returns all 8 lines of the selected port at once.
// - A line write changes only the addressed line of the selected port.
// - A line read returns the state of the one addressed line.
// - Each port has a direction bitmap, 1 makes a line output, 0 input.
// - The direction bitmap resets to 0, all lines inputs.
// - Each port holds an open-drain or push-pull drive style.
// - The drive style resets to push-pull.
// - In open-drain style a high output releases the pin, low drives.
// - An active-port index, reset 0, steers configuration; 0 only valid.
// - A line read reports 0 for a low line and 1 for a high line.
// - A global timeout in milliseconds, default 30000, bounds operations.
// - A port read shows the external level on inputs, own drive on outputs.
// - A port write drives only output lines; inputs stay undriven.
`ifndef BWD_DEFS_SVH
`define BWD_DEFS_SVH

`define BWD_ADDR_PORT     12'h000
`define BWD_ADDR_LINE     12'h004
`define BWD_ADDR_DIR      12'h008
`define BWD_ADDR_STYLE    12'h00C
`define BWD_ADDR_SEL      12'h010
`define BWD_ADDR_TIMEOUT  12'h014
`define BWD_ADDR_STATUS   12'h018

`define BWD_LINE_NUM_LSB  8
`define BWD_LINE_NUM_MSB  10
`define BWD_LINE_VAL_BIT  0
`define BWD_STYLE_BIT     0
`define BWD_STAT_BUSY     0
`define BWD_STAT_TMO      1

`define BWD_RST_DIR       8'h00
`define BWD_RST_OUT       8'h00
`define BWD_RST_SEL       8'h00
`define BWD_RST_TMO_MS    32'h0000_7530
`define BWD_MS_NS         1000000
`define BWD_CLK_NS        100
`define BWD_MS_CYCLES     (`BWD_MS_NS / `BWD_CLK_NS)

`endif

// ===== rtl/bwd_pkg.sv
// Purpose: Types for the byte-wide DIO port
// Assumes: Nothing
// Notes:   Constants live in bwd_defs.svh
package bwd_pkg;
  typedef enum logic {
    BWD_PUSH_PULL,
    BWD_OPEN_DRAIN
  } bwd_style_t;
endpackage

// ===== rtl/bwd_ms_tick.sv
// Purpose: One-cycle pulse every millisecond
// Assumes: pclk at the rate set in the defs header
// Notes:   Divider only
`timescale 1ns/1ns
`include "bwd_defs.svh"
module bwd_ms_tick #(
  parameter int unsigned CYCLES = `BWD_MS_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Millisecond tick
  output logic      tick
);
  logic [15:0] cnt_q;
  wire         wrap = (cnt_q == 16'(CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
  assign tick = wrap;
endmodule

// ===== rtl/bwd_pin_cell.sv
// Purpose: One DIO line driver, combinational; the output latch is in the port
// Assumes: Pin input synchronous to pclk
// Notes:   Output enable high while driving
`timescale 1ns/1ns
module bwd_pin_cell (
  // Control
  input  wire logic dir_out,
  input  wire logic open_drain,
  input  wire logic level,
  // Pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe,
  // Readback
  output logic      state
);
  // Open drain only pulls low, high releases
  assign pin_o  = open_drain ? 1'b0 : level;
  assign pin_oe = dir_out & (open_drain ? ~level : 1'b1);
  assign state  = dir_out ? level : pin_i;
endmodule

// ===== rtl/bwd_dio_port.sv
// Purpose: APB slave and logic of an 8-line digital I/O port
// Assumes: One port; pins synchronous to pclk
// Notes:   Zero wait states; unmapped address gives pslverr
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`include "bwd_defs.svh"
module bwd_dio_port #(
  parameter int unsigned LINES     = 8,
  parameter int unsigned MS_CYCLES = `BWD_MS_CYCLES
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Pins
  input  wire logic [LINES-1:0]  dio_i,
  output logic [LINES-1:0]       dio_o,
  output logic [LINES-1:0]       dio_oe,
  // Operation timeout
  input  wire logic              op_start,
  input  wire logic              op_done,
  output logic                   op_timeout
);
  logic [LINES-1:0]    out_q;
  logic [LINES-1:0]    dir_q;
  bwd_pkg::bwd_style_t style_q;
  logic [7:0]          sel_q;
  logic [31:0]         tmo_ms_q;
  logic [31:0]         ms_cnt_q;
  logic                busy_q;
  logic                tmo_q;
  logic [31:0]         rdata_q;
  logic                ms_tick;
  logic [LINES-1:0]    line_state;
  logic [2:0]          rd_idx_q;

  wire access = psel & penable;
  wire wr     = access & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire hit_port = (paddr == `BWD_ADDR_PORT);
  wire hit_line = (paddr == `BWD_ADDR_LINE);
  wire hit_dir  = (paddr == `BWD_ADDR_DIR);
  wire hit_sty  = (paddr == `BWD_ADDR_STYLE);
  wire hit_sel  = (paddr == `BWD_ADDR_SEL);
  wire hit_tmo  = (paddr == `BWD_ADDR_TIMEOUT);
  wire hit_stat = (paddr == `BWD_ADDR_STATUS);
  wire mapped   = hit_port | hit_line | hit_dir | hit_sty | hit_sel
                | hit_tmo | hit_stat;
  // Only port 0 exists; configuration with another index is ignored
  wire sel_ok   = (sel_q == `BWD_RST_SEL);
  wire b0       = pstrb[0];
  wire b1       = pstrb[1];
  wire [2:0] line_idx = pwdata[`BWD_LINE_NUM_MSB:`BWD_LINE_NUM_LSB];
  wire       line_val = pwdata[`BWD_LINE_VAL_BIT];

  // Write byte to latch; line write touches one bit only
  logic [LINES-1:0] out_d;
  always_comb begin
    out_d = out_q;
    if (wr && hit_port && b0) begin
      out_d = pwdata[LINES-1:0];
    end else if (wr && hit_line && b0 && b1) begin
      out_d[line_idx] = line_val;
    end
  end

  wire [LINES-1:0] dir_d = (wr && hit_dir && b0 && sel_ok)
                         ? pwdata[LINES-1:0] : dir_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q   <= `BWD_RST_OUT;
      dir_q   <= `BWD_RST_DIR;
      style_q <= bwd_pkg::BWD_PUSH_PULL;
      sel_q   <= `BWD_RST_SEL;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      if (wr && hit_sty && b0 && sel_ok) begin
        style_q <= bwd_pkg::bwd_style_t'(pwdata[`BWD_STYLE_BIT]);
      end
      if (wr && hit_sel && b0) begin
        sel_q <= pwdata[7:0];
      end
    end
  end

  // Per-line driver
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      bwd_pin_cell u_cell (
        .dir_out    (dir_q[g]),
        .open_drain (style_q == bwd_pkg::BWD_OPEN_DRAIN),
        .level      (out_q[g]),
        .pin_i      (dio_i[g]),
        .pin_o      (dio_o[g]),
        .pin_oe     (dio_oe[g]),
        .state      (line_state[g])
      );
    end
  endgenerate

  // Timeout supervisor counting milliseconds
  bwd_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick)
  );

  // Software clear of the sticky timeout flag
  wire tmo_clr = wr & hit_stat & b0 & pwdata[`BWD_STAT_TMO];
  wire tmo_hit = busy_q & ~op_done & ms_tick
               & (ms_cnt_q + 32'h0000_0001 >= tmo_ms_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_ms_q <= `BWD_RST_TMO_MS;
      ms_cnt_q <= 32'h0000_0000;
      busy_q   <= 1'b0;
      tmo_q    <= 1'b0;
    end else begin
      if (wr && hit_tmo && (&pstrb)) begin
        tmo_ms_q <= pwdata;
      end
      if (op_start) begin
        busy_q   <= 1'b1;
        ms_cnt_q <= 32'h0000_0000;
      end else if (busy_q && op_done) begin
        busy_q <= 1'b0;
      end else if (busy_q && ms_tick) begin
        ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        if (tmo_hit) begin
          busy_q <= 1'b0;
        end
      end
      // Expiry beats a software clear in the same cycle
      if (op_start) begin
        tmo_q <= 1'b0;
      end else if (tmo_hit) begin
        tmo_q <= 1'b1;
      end else if (tmo_clr) begin
        tmo_q <= 1'b0;
      end
    end
  end
  assign op_timeout = tmo_q;

  // Read mux; bits above the port width read zero, except the 32-bit timeout
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_port) begin
      rd_d[LINES-1:0] = line_state;
    end else if (hit_line) begin
      rd_d[`BWD_LINE_VAL_BIT] = line_state[rd_idx_q];
    end else if (hit_dir) begin
      rd_d[LINES-1:0] = dir_q;
    end else if (hit_sty) begin
      rd_d[`BWD_STYLE_BIT] = style_q;
    end else if (hit_sel) begin
      rd_d[7:0] = sel_q;
    end else if (hit_tmo) begin
      rd_d = tmo_ms_q;
    end else if (hit_stat) begin
      rd_d[`BWD_STAT_BUSY] = busy_q;
      rd_d[`BWD_STAT_TMO]  = tmo_q;
    end
  end

  // Line read addresses the line set by the last line write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx_q <= 3'h0;
    end else if (wr && hit_line && b0 && b1) begin
      rd_idx_q <= line_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rd_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = access & ~mapped;

  // Line access
  a_line_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_line && b0 && b1 |=> out_q[$past(line_idx)] == $past(line_val))
    else $error("line write value lost");

  a_line_index: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_line && b0 && b1 |=> rd_idx_q == $past(line_idx))
    else $error("line index not kept");

  a_line_value: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_line |=> prdata[0] == $past(line_state[rd_idx_q]))
    else $error("line read value wrong");

  a_line_upper: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_line |=> prdata[31:1] == '0)
    else $error("line read upper bits set");

  // Port access
  a_port_upper: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_port |=> prdata[31:LINES] == '0)
    else $error("port read upper bits set");

  a_port_all: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && hit_port |=> prdata[LINES-1:0] == $past(line_state))
    else $error("port read not one snapshot");

  a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data moved");

  a_state_mix: assert property (@(posedge pclk) disable iff (!presetn)
    line_state == ((dio_i & ~dir_q) | (out_q & dir_q)))
    else $error("line state mix wrong");

  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && (hit_port || hit_line)) |=> $stable(out_q))
    else $error("latch changed without write");

  a_drive_level: assert property (@(posedge pclk) disable iff (!presetn)
    (dio_oe & dio_o) == (dio_oe & out_q))
    else $error("driven level differs from latch");

  // Drive style
  a_od_enable: assert property (@(posedge pclk) disable iff (!presetn)
    style_q == bwd_pkg::BWD_OPEN_DRAIN |-> dio_oe == (dir_q & ~out_q))
    else $error("open drain enable wrong");

  a_od_low: assert property (@(posedge pclk) disable iff (!presetn)
    style_q == bwd_pkg::BWD_OPEN_DRAIN |-> dio_o == '0)
    else $error("open drain level not low");

  a_style_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_sty && b0 && sel_ok |=>
      style_q == bwd_pkg::bwd_style_t'($past(pwdata[`BWD_STYLE_BIT])))
    else $error("drive style not stored");

  a_style_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_sty) |=> $stable(style_q))
    else $error("drive style moved");

  // Direction and port index
  a_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_dir) |=> $stable(dir_q))
    else $error("direction moved");

  a_dir_bad_sel: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_dir && !sel_ok |=> $stable(dir_q))
    else $error("direction written for bad port");

  a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_sel && b0 |=> sel_q == $past(pwdata[7:0]))
    else $error("port index not stored");

  a_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_sel) |=> $stable(sel_q))
    else $error("port index moved");

  // Operation timeout
  a_busy_start: assert property (@(posedge pclk) disable iff (!presetn)
    op_start |=> busy_q && !tmo_q)
    else $error("start did not arm");

  a_done_ends: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && op_done && !op_start |=> !busy_q && !$rose(tmo_q))
    else $error("done did not end watch");

  a_tmo_late: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tmo_q) |-> ms_cnt_q >= tmo_ms_q)
    else $error("timeout came early");

  a_tmo_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_q && !op_start && !tmo_clr |=> tmo_q)
    else $error("timeout flag dropped");

  a_tmo_clear: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_clr && !op_start && !tmo_hit |=> !tmo_q)
    else $error("timeout flag not cleared");

  a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && !op_start && !op_done && ms_tick |=>
      ms_cnt_q == $past(ms_cnt_q) + 32'h0000_0001)
    else $error("millisecond count skipped");

  a_cnt_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !busy_q && !op_start |=> $stable(ms_cnt_q))
    else $error("count moved while idle");

  a_tmo_reg: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_tmo && (&pstrb) |=> tmo_ms_q == $past(pwdata))
    else $error("timeout value not stored");


  a_port_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_port && b0 |=> out_q == $past(pwdata[LINES-1:0]))
    else $error("port write not latched");
  a_line_only: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_line && b0 && b1 |=> $countones(out_q ^ $past(out_q)) <= 1)
    else $error("line write touched other lines");
  a_inputs_free: assert property (@(posedge pclk) disable iff (!presetn)
    (dio_oe & ~dir_q) == '0)
    else $error("input line driven");
  a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
    style_q == bwd_pkg::BWD_OPEN_DRAIN |-> (dio_oe & out_q) == '0)
    else $error("open drain drives high");
  a_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
    style_q == bwd_pkg::BWD_PUSH_PULL |-> dio_oe == dir_q && dio_o == out_q)
    else $error("push pull not driving");
  a_port_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit_port |=>
      prdata[LINES-1:0] == (($past(dio_i) & ~$past(dir_q))
                         | ($past(out_q) & $past(dir_q))))
    else $error("port read wrong");
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_dir && b0 && sel_ok |=> dir_q == $past(pwdata[LINES-1:0]))
    else $error("direction not stored");
  a_bad_port: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_ok |=> $stable(dir_q) && $stable(style_q))
    else $error("config changed for bad port");
  a_timeout_set: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tmo_q) |-> $past(busy_q) && !busy_q)
    else $error("timeout without operation");
endmodule

// ===== verification/bwd_ext_circuit.sv
// Purpose: External circuit on the DIO lines
// Assumes: Pull-up on every line
// Notes:   Drives a line only where drv_en is set
`timescale 1ns/1ns
module bwd_ext_circuit (
  // Device side
  input  wire logic [7:0] dio_o,
  input  wire logic [7:0] dio_oe,
  // Stimulus
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  // Line levels
  output logic      [7:0] dio_i
);
  // Device drive wins; released lines float up
  assign dio_i = (dio_oe & dio_o) | (~dio_oe & drv_en & drv_val)
               | (~dio_oe & ~drv_en);
endmodule

// ===== verification/bwd_dio_port_bench.sv
// Purpose: Self-checking bench for the byte-wide DIO port
// Assumes: Zero-wait APB slave, millisecond shortened to 4 cycles
// Notes:   Port number is 0, except for one direction write with index 1
`timescale 1ns/1ns
`include "bwd_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module bwd_dio_port_bench;
  logic        pclk, presetn, psel, penable, pwrite, op_start, op_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, op_timeout, err;
  logic [7:0]  dio_i, dio_o, dio_oe, drv_en, drv_val;
  int          n_fail, cmp_count;

  always #50 pclk = ~pclk;

  bwd_dio_port #(.LINES(8), .MS_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .dio_i(dio_i),
    .dio_o(dio_o), .dio_oe(dio_oe), .op_start(op_start),
    .op_done(op_done), .op_timeout(op_timeout));

  bwd_ext_circuit ext (.dio_o(dio_o), .dio_oe(dio_oe), .drv_en(drv_en),
    .drv_val(drv_val), .dio_i(dio_i));

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
    repeat (3) @(posedge pclk);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask

  task lchk(input logic [2:0] ln, input logic v, input logic [7:0] ex);
    apb(1'b1, `BWD_ADDR_LINE, {21'h00_0000, ln, 7'h00, v});
    @(negedge pclk);
    `CHK("line out", ex, dio_o & dio_oe)
    rchk("line rd", `BWD_ADDR_LINE, {31'h0000_0000, v});
  endtask

  task t_reset;
    rchk("dir", `BWD_ADDR_DIR, 32'h0000_0000);
    rchk("style", `BWD_ADDR_STYLE, 32'h0000_0000);
    rchk("sel", `BWD_ADDR_SEL, 32'h0000_0000);
    rchk("tmo", `BWD_ADDR_TIMEOUT, 32'h0000_7530);
    rchk("port", `BWD_ADDR_PORT, 32'h0000_00FF);
    `CHK("oe", 8'h00, dio_oe)
    $display("test reset done");
  endtask

  task t_port;
    drv_en <= 8'h0F;
    drv_val <= 8'h03;
    apb(1'b1, `BWD_ADDR_DIR, 32'h0000_00F0);
    apb(1'b1, `BWD_ADDR_PORT, 32'h0000_00A5);
    @(negedge pclk);
    `CHK("oe", 8'hF0, dio_oe)
    `CHK("out", 8'hA0, dio_o & dio_oe)
    rchk("port", `BWD_ADDR_PORT, 32'h0000_00A3);
    lchk(3'd6, 1'b1, 8'hE0);
    lchk(3'd7, 1'b0, 8'h60);
    $display("test port and line done");
  endtask

  task t_style;
    apb(1'b1, `BWD_ADDR_STYLE, 32'h0000_0001);
    @(negedge pclk);
    `CHK("od oe", 8'h90, dio_oe)
    `CHK("od out", 8'h00, dio_o & dio_oe)
    rchk("od port", `BWD_ADDR_PORT, 32'h0000_0063);
    apb(1'b1, `BWD_ADDR_SEL, 32'h0000_0001);
    apb(1'b1, `BWD_ADDR_DIR, 32'h0000_00FF);
    apb(1'b1, `BWD_ADDR_SEL, 32'h0000_0000);
    rchk("dir kept", `BWD_ADDR_DIR, 32'h0000_00F0);
    apb(1'b1, `BWD_ADDR_STYLE, 32'h0000_0000);
    @(negedge pclk);
    `CHK("pp oe", 8'hF0, dio_oe)
    apb(1'b1, 12'h01C, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    $display("test style done");
  endtask

  task t_timeout;
    int n;
    apb(1'b1, `BWD_ADDR_TIMEOUT, 32'h0000_0002);
    op_start <= 1'b1;
    @(posedge pclk);
    op_start <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    `CHK("early tmo", 1'b0, op_timeout)
    n = 0;
    while (op_timeout !== 1'b1 && n < 8) begin
      @(negedge pclk);
      n++;
    end
    `CHK("tmo", 1'b1, op_timeout)
    rchk("status", `BWD_ADDR_STATUS, 32'h0000_0002);
    apb(1'b1, `BWD_ADDR_STATUS, 32'h0000_0002);
    @(posedge pclk);
    op_start <= 1'b1;
    @(posedge pclk);
    op_start <= 1'b0;
    op_done <= 1'b1;
    @(posedge pclk);
    op_done <= 1'b0;
    repeat (14) @(posedge pclk);
    @(negedge pclk);
    `CHK("no tmo", 1'b0, op_timeout)
    $display("test timeout done");
  endtask

  task t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("rst oe", 8'h00, dio_oe)
    rchk("rst dir", `BWD_ADDR_DIR, 32'h0000_0000);
    rchk("rst style", `BWD_ADDR_STYLE, 32'h0000_0000);
    rchk("rst port", `BWD_ADDR_PORT, 32'h0000_00F3);
    apb(1'b1, `BWD_ADDR_DIR, 32'h0000_00F0);
    @(negedge pclk);
    `CHK("rst out", 8'h00, dio_o & dio_oe)
    $display("test mid reset done");
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    results();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, op_start, op_done} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    drv_en = 8'h00;
    drv_val = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port();
    t_style();
    t_midreset();
    t_timeout();
    results();
  end
endmodule
